// ===== hdl/scsr_reg8.v
// A byte-wide software register with a write mask and a reset value.
`timescale 1ns/1ps
module scsr_reg8 #(
  parameter [7:0] RESET_VAL = 8'h00,  // Value after reset.
  parameter [7:0] WMASK     = 8'hFF   // Bits that software may write.
) (
  input  wire       clk,      // System clock.
  input  wire       reset_n,  // Synchronous reset, active low.
  input  wire       ce,       // Clock enable.
  input  wire       we,       // Write strobe for the low byte lane.
  input  wire [7:0] wdata,    // Write data.
  output reg  [7:0] q         // Stored value.
);

  ////////////////////////////////////////////////////////////////////////////
  // Unwritable bits stay at their reset value; nothing but reset or a write changes the byte.
  always @(posedge clk) begin
    if (!reset_n) begin
      q <= RESET_VAL;
    end else if (ce && we) begin
      q <= (wdata & WMASK) | (RESET_VAL & ~WMASK);
    end
  end

endmodule // scsr_reg8

// ===== hdl/scsr_regs.vh
// Register offsets, field positions, reset values and timing figures of the system bank.
`ifndef SCSR_REGS_VH
`define SCSR_REGS_VH

// Byte addresses of the two registers on the peripheral bus.
`define SCSR_ADDR_W            24
`define SCSR_CFG_ADDR          24'hFFF910
`define SCSR_STAT_ADDR         24'hFFF914

// Field positions of the module configuration register.
`define SCSR_CFG_IO_ZONE_BIT   0
`define SCSR_CFG_PLL_PIN_BIT   1
`define SCSR_CFG_MAIN_PIN_BIT  2
`define SCSR_CFG_SLOW_PIN_BIT  3
`define SCSR_CFG_USB_EN_BIT    4
`define SCSR_CFG_MISC_SLEW_BIT 5
`define SCSR_CFG_MEM_SLEW_BIT  6

// Writable bits and reset value of the configuration register.
`define SCSR_CFG_WMASK         8'h7F
`define SCSR_CFG_RESET         8'h10

// Field positions of the module status register.
`define SCSR_STAT_STRAP_LSB    0
`define SCSR_STAT_ANY_BUSY_BIT 3
`define SCSR_STAT_DF_BUSY_BIT  4

// AXI response codes.
`define SCSR_RESP_OKAY         2'h0
`define SCSR_RESP_SLVERR       2'h2

// Access time lost with slow memory slew, and the clock period it is measured against.
`define SCSR_SLOW_SLEW_LOSS_NS 5
`define SCSR_CLK_PERIOD_NS     40
`define SCSR_SLOW_SLEW_LOSS_CYC ((`SCSR_SLOW_SLEW_LOSS_NS + `SCSR_CLK_PERIOD_NS - 1) / `SCSR_CLK_PERIOD_NS)

`endif

// ===== hdl/scsr_strap_pin.v
// One environment strap pin that is sampled at reset and may later carry a clock out.
`timescale 1ns/1ps
module scsr_strap_pin (
  input  wire clk,       // System clock.
  input  wire reset_n,   // Synchronous reset, active low.
  input  wire ce,        // Clock enable.
  input  wire pin_i,     // Level seen on the pin.
  input  wire src_clk,   // Clock level to drive out.
  input  wire drive_en,  // Drive the clock onto the pin.
  output reg  pin_o,     // Level driven onto the pin.
  output reg  pin_oe_n,  // Output enable, low while driving.
  output reg  strap      // Level caught during reset.
);

  ////////////////////////////////////////////////////////////////////////////
  // The strap is caught on every edge while reset is held and then frozen.
  // The pin is released during reset so that the external strap sets its level.
  always @(posedge clk) begin
    if (!reset_n) begin
      strap    <= pin_i;
      pin_o    <= 1'b0;
      pin_oe_n <= 1'b1;
    end else if (ce) begin
      pin_o    <= drive_en ? src_clk : 1'b0;
      pin_oe_n <= ~drive_en;
    end
  end

endmodule // scsr_strap_pin

// ===== hdl/scsr_top.v
// System configuration and status registers behind an AXI4-Lite slave.
`timescale 1ns/1ps
`include "scsr_regs.vh"

module scsr_top (
  input  wire        CLK,               // System clock, 25 MHz.
  input  wire        RESET_N,           // Synchronous reset, active low.
  input  wire        CE,                // Clock enable, freezes state while low.
  // AXI4-Lite write address channel.
  input  wire [23:0] S_AXI_AWADDR,      // Write byte address.
  input  wire [2:0]  S_AXI_AWPROT,      // Protection, unused.
  input  wire        S_AXI_AWVALID,     // Write address valid.
  output wire        S_AXI_AWREADY,     // Write address ready.
  // AXI4-Lite write data channel.
  input  wire [31:0] S_AXI_WDATA,       // Write data.
  input  wire [3:0]  S_AXI_WSTRB,       // Write byte strobes.
  input  wire        S_AXI_WVALID,      // Write data valid.
  output wire        S_AXI_WREADY,      // Write data ready.
  // AXI4-Lite write response channel.
  output reg  [1:0]  S_AXI_BRESP,       // Write response.
  output reg         S_AXI_BVALID,      // Write response valid.
  input  wire        S_AXI_BREADY,      // Write response ready.
  // AXI4-Lite read address channel.
  input  wire [23:0] S_AXI_ARADDR,      // Read byte address.
  input  wire [2:0]  S_AXI_ARPROT,      // Protection, unused.
  input  wire        S_AXI_ARVALID,     // Read address valid.
  output wire        S_AXI_ARREADY,     // Read address ready.
  // AXI4-Lite read data channel.
  output reg  [31:0] S_AXI_RDATA,       // Read data.
  output reg  [1:0]  S_AXI_RRESP,       // Read response.
  output reg         S_AXI_RVALID,      // Read data valid.
  input  wire        S_AXI_RREADY,      // Read data ready.
  // Environment strap pins, each split into input, output and enable.
  input  wire [2:0]  ENV_STRAP_I,       // Levels seen on the strap pins.
  output wire [2:0]  ENV_STRAP_O,       // Levels driven onto the strap pins.
  output wire [2:0]  ENV_STRAP_OE_N,    // Output enables, low while driving.
  // Clock sources that may be routed to the strap pins.
  input  wire        PLL_CLOCK_IN,      // PLL clock level.
  input  wire        MAIN_CLOCK_IN,     // Main clock level.
  input  wire        SLOW_CLOCK_IN,     // Slow clock level.
  // USB transceiver power inputs.
  input  wire        USB_CTRL_LOW_POWER_REQ, // Controller asks for low power.
  input  wire        FUNC_WORD_USB_ENABLE,   // Enable bit of the stored function word.
  // Flash interface busy flags.
  input  wire        FLASH_INTERFACE_BUSY,   // Program flash interface busy flag.
  input  wire        DATA_FLASH_BUSY,        // Data flash interface busy flag.
  // Configuration outputs.
  output reg         IO_ZONE_EXTERNAL_BUS_EN, // External bus enabled for the I/O zone.
  output reg         USB_XCVR_LOW_POWER,      // External transceiver in low power.
  output reg         MISC_IO_SLOW_SLEW,       // Slow slew on miscellaneous outputs.
  output reg         MEM_IO_SLOW_SLEW         // Slow slew on memory interface outputs.
);

  ////////////////////////////////////////////////////////////////////////////
  // Write channel holding state.
  reg         aw_hold_q;   // Write address taken, waiting for data.
  reg  [23:0] aw_addr_q;   // Held write address.
  reg         w_hold_q;    // Write data taken, waiting for address.
  reg  [7:0]  w_data_q;    // Held low write byte.
  reg         w_strb_q;    // Held low byte strobe.

  // Status register and configuration storage.
  reg  [1:0]  busy_q;      // Mirrored busy flags, data flash in bit 1.
  wire [7:0]  cfg_q;       // Configuration register contents.
  wire [2:0]  strap_state; // Straps caught at reset.
  wire [7:0]  stat_word;   // Status register image.

  // Write path decode.
  wire        aw_hs;       // Write address handshake.
  wire        w_hs;        // Write data handshake.
  wire        aw_have;     // Address available this cycle.
  wire        w_have;      // Data available this cycle.
  wire        do_write;    // Both halves present, perform the write.
  wire [23:0] wr_addr;     // Effective write address.
  wire [7:0]  wr_byte;     // Effective low write byte.
  wire        wr_strb;     // Effective low byte strobe.
  wire        wr_hit_cfg;  // Write targets the configuration word.
  wire        wr_hit_stat; // Write targets the status word.
  wire        cfg_we;      // Configuration byte write strobe.

  // Read path decode.
  wire        ar_hs;       // Read address handshake.
  reg  [31:0] rd_word;     // Read data for the requested address.
  reg  [1:0]  rd_resp;     // Read response for the requested address.

  ////////////////////////////////////////////////////////////////////////////
  // Channel readiness: no new halves are taken while a response waits.
  // Ready stays low while the clock enable is low, so no transfer looks taken.
  assign S_AXI_AWREADY = CE && !aw_hold_q && !S_AXI_BVALID;
  assign S_AXI_WREADY  = CE && !w_hold_q && !S_AXI_BVALID;
  assign S_AXI_ARREADY = CE && !S_AXI_RVALID;

  assign aw_hs = CE && S_AXI_AWVALID && S_AXI_AWREADY;
  assign w_hs  = CE && S_AXI_WVALID && S_AXI_WREADY;
  assign ar_hs = CE && S_AXI_ARVALID && S_AXI_ARREADY;

  // Either half may arrive first; the write happens once both are present.
  assign aw_have  = aw_hold_q || aw_hs;
  assign w_have   = w_hold_q || w_hs;
  assign do_write = CE && aw_have && w_have && !S_AXI_BVALID;

  assign wr_addr = aw_hold_q ? aw_addr_q : S_AXI_AWADDR;
  assign wr_byte = w_hold_q ? w_data_q : S_AXI_WDATA[7:0];
  assign wr_strb = w_hold_q ? w_strb_q : S_AXI_WSTRB[0];

  // Only the aligned word decodes; the low two address bits must be zero.
  assign wr_hit_cfg  = (wr_addr == `SCSR_CFG_ADDR);
  assign wr_hit_stat = (wr_addr == `SCSR_STAT_ADDR);

  // The status word has no write strobe, so writes to it leave it unchanged.
  assign cfg_we = do_write && wr_hit_cfg && wr_strb;

  ////////////////////////////////////////////////////////////////////////////
  // Holding registers for a half that arrived before its partner.
  always @(posedge CLK) begin
    if (!RESET_N) begin
      aw_hold_q <= 1'b0;
      aw_addr_q <= 24'h000000;
      w_hold_q  <= 1'b0;
      w_data_q  <= 8'h00;
      w_strb_q  <= 1'b0;
    end else if (CE) begin
      if (do_write) begin
        aw_hold_q <= 1'b0;
        w_hold_q  <= 1'b0;
      end else begin
        if (aw_hs) begin
          aw_hold_q <= 1'b1;
          aw_addr_q <= S_AXI_AWADDR;
        end
        if (w_hs) begin
          w_hold_q <= 1'b1;
          w_data_q <= S_AXI_WDATA[7:0];
          w_strb_q <= S_AXI_WSTRB[0];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write response: okay for the two words, slave error elsewhere.
  always @(posedge CLK) begin
    if (!RESET_N) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= `SCSR_RESP_OKAY;
    end else if (CE) begin
      if (do_write) begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= (wr_hit_cfg || wr_hit_stat) ? `SCSR_RESP_OKAY : `SCSR_RESP_SLVERR;
      end else if (S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration byte; power modes never touch it, only reset and a bus write do.
  scsr_reg8 #(
    .RESET_VAL (`SCSR_CFG_RESET),
    .WMASK     (`SCSR_CFG_WMASK)
  ) u_cfg (
    .clk     (CLK),
    .reset_n (RESET_N),
    .ce      (CE),
    .we      (cfg_we),
    .wdata   (wr_byte),
    .q       (cfg_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Strap pin 0 carries the PLL clock when enabled.
  scsr_strap_pin u_pin_pll (
    .clk      (CLK),
    .reset_n  (RESET_N),
    .ce       (CE),
    .pin_i    (ENV_STRAP_I[0]),
    .src_clk  (PLL_CLOCK_IN),
    .drive_en (cfg_q[`SCSR_CFG_PLL_PIN_BIT]),
    .pin_o    (ENV_STRAP_O[0]),
    .pin_oe_n (ENV_STRAP_OE_N[0]),
    .strap    (strap_state[0])
  );

  // Strap pin 1 carries the main clock when enabled.
  scsr_strap_pin u_pin_main (
    .clk      (CLK),
    .reset_n  (RESET_N),
    .ce       (CE),
    .pin_i    (ENV_STRAP_I[1]),
    .src_clk  (MAIN_CLOCK_IN),
    .drive_en (cfg_q[`SCSR_CFG_MAIN_PIN_BIT]),
    .pin_o    (ENV_STRAP_O[1]),
    .pin_oe_n (ENV_STRAP_OE_N[1]),
    .strap    (strap_state[1])
  );

  // Strap pin 2 carries the slow clock when enabled.
  scsr_strap_pin u_pin_slow (
    .clk      (CLK),
    .reset_n  (RESET_N),
    .ce       (CE),
    .pin_i    (ENV_STRAP_I[2]),
    .src_clk  (SLOW_CLOCK_IN),
    .drive_en (cfg_q[`SCSR_CFG_SLOW_PIN_BIT]),
    .pin_o    (ENV_STRAP_O[2]),
    .pin_oe_n (ENV_STRAP_OE_N[2]),
    .strap    (strap_state[2])
  );

  ////////////////////////////////////////////////////////////////////////////
  // Busy flags are copied on every edge with the clock enable high; they are never cleared by software.
  // A change on a busy input therefore shows in a read taken one edge later.
  always @(posedge CLK) begin
    if (!RESET_N) begin
      busy_q <= 2'h0;
    end else if (CE) begin
      busy_q[0] <= FLASH_INTERFACE_BUSY;
      busy_q[1] <= DATA_FLASH_BUSY;
    end
  end

  // Status image with reserved bits tied low.
  assign stat_word = {3'h0, busy_q[1], busy_q[0], strap_state};

  ////////////////////////////////////////////////////////////////////////////
  // Read decode; reserved upper bits of both words read as zero.
  always @* begin
    rd_word = 32'h00000000;
    rd_resp = `SCSR_RESP_OKAY;
    case (S_AXI_ARADDR)
      `SCSR_CFG_ADDR: begin
        rd_word = {24'h000000, cfg_q};
      end
      `SCSR_STAT_ADDR: begin
        rd_word = {24'h000000, stat_word};
      end
      default: begin
        rd_resp = `SCSR_RESP_SLVERR;
      end
    endcase
  end

  // Read data channel, answered one cycle after the address is taken.
  always @(posedge CLK) begin
    if (!RESET_N) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA  <= 32'h00000000;
      S_AXI_RRESP  <= `SCSR_RESP_OKAY;
    end else if (CE) begin
      if (ar_hs) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA  <= rd_word;
        S_AXI_RRESP  <= rd_resp;
      end else if (S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration outputs, registered so they change one edge after the store.
  // The transceiver is forced low when the enable bit is clear; otherwise the
  // controller request and the function word decide.
  always @(posedge CLK) begin
    if (!RESET_N) begin
      IO_ZONE_EXTERNAL_BUS_EN <= 1'b0;
      USB_XCVR_LOW_POWER      <= 1'b1;
      MISC_IO_SLOW_SLEW       <= 1'b0;
      MEM_IO_SLOW_SLEW        <= 1'b0;
    end else if (CE) begin
      IO_ZONE_EXTERNAL_BUS_EN <= cfg_q[`SCSR_CFG_IO_ZONE_BIT];
      USB_XCVR_LOW_POWER      <= !cfg_q[`SCSR_CFG_USB_EN_BIT] ||
                                 USB_CTRL_LOW_POWER_REQ ||
                                 !FUNC_WORD_USB_ENABLE;
      MISC_IO_SLOW_SLEW       <= cfg_q[`SCSR_CFG_MISC_SLEW_BIT];
      MEM_IO_SLOW_SLEW        <= cfg_q[`SCSR_CFG_MEM_SLEW_BIT];
    end
  end

endmodule // scsr_top

// ===== tb/scsr_top_monitor.sv
// Concurrent checks on the ports of the system configuration and status bank.
`timescale 1ns/1ps
`include "scsr_regs.vh"
module scsr_top_monitor (
  input wire        CLK,                     // Clock.
  input wire        RESET_N,                 // Reset, active low.
  input wire        CE,                      // Clock enable.
  input wire        S_AXI_AWREADY,           // Write address ready.
  input wire        S_AXI_WREADY,            // Write data ready.
  input wire        S_AXI_BVALID,            // Write response valid.
  input wire [23:0] S_AXI_ARADDR,            // Read address.
  input wire        S_AXI_ARVALID,           // Read address valid.
  input wire        S_AXI_ARREADY,           // Read address ready.
  input wire [31:0] S_AXI_RDATA,             // Read data.
  input wire [1:0]  S_AXI_RRESP,             // Read response.
  input wire        S_AXI_RVALID,            // Read data valid.
  input wire [2:0]  ENV_STRAP_I,             // Strap pin levels.
  input wire [2:0]  ENV_STRAP_O,             // Strap pin drive.
  input wire [2:0]  ENV_STRAP_OE_N,          // Strap pin enables.
  input wire        PLL_CLOCK_IN,            // PLL clock.
  input wire        MAIN_CLOCK_IN,           // Main clock.
  input wire        SLOW_CLOCK_IN,           // Slow clock.
  input wire        USB_CTRL_LOW_POWER_REQ,  // Low power request.
  input wire        FUNC_WORD_USB_ENABLE,    // Function word enable.
  input wire        FLASH_INTERFACE_BUSY,    // Program flash busy.
  input wire        DATA_FLASH_BUSY,         // Data flash busy.
  input wire        IO_ZONE_EXTERNAL_BUS_EN, // I/O zone bus enable.
  input wire        USB_XCVR_LOW_POWER,      // Transceiver low power.
  input wire        MISC_IO_SLOW_SLEW,       // Miscellaneous slew.
  input wire        MEM_IO_SLOW_SLEW         // Memory slew.
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  ////////////////////////////////////////////////////////////////////////////////
  // Straps are caught on every reset edge; read handshakes are decoded once.
  logic [2:0] strap_q;
  wire        ar_hs = S_AXI_ARVALID && S_AXI_ARREADY && CE;
  wire        ar_cfg = S_AXI_ARADDR == `SCSR_CFG_ADDR;
  wire        ar_st = S_AXI_ARADDR == `SCSR_STAT_ADDR;
  wire        stepped = RESET_N && CE;  // State advanced on this edge.
  always @(posedge CLK) begin
    if (!RESET_N) begin
      strap_q <= ENV_STRAP_I;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read answers, output timing, pin behaviour and write blocking.
  a_rd_cfg_word: assert property (ar_hs && ar_cfg |=> S_AXI_RVALID &&
    S_AXI_RRESP == 2'h0 && S_AXI_RDATA[31:7] == 25'h0) else $error("config read wrong");
  a_rd_strap_bits: assert property (ar_hs && ar_st |=>
    S_AXI_RDATA[2:0] == strap_q && S_AXI_RDATA[31:5] == 27'h0) else $error("strap bits wrong");
  a_rd_busy_bits: assert property (ar_hs && ar_st && $past(stepped) |=>
    S_AXI_RDATA[4:3] == {$past(DATA_FLASH_BUSY, 2), $past(FLASH_INTERFACE_BUSY, 2)})
    else $error("busy bits wrong");
  a_rd_unmapped: assert property (ar_hs && !ar_cfg && !ar_st |=>
    S_AXI_RRESP == 2'h2 && S_AXI_RDATA == 32'h0) else $error("unmapped read wrong");
  a_usb_force_low: assert property ($past(stepped) && ($past(USB_CTRL_LOW_POWER_REQ) ||
    !$past(FUNC_WORD_USB_ENABLE)) |-> USB_XCVR_LOW_POWER) else $error("usb not low power");
  a_cfg_out_hold: assert property ($changed({IO_ZONE_EXTERNAL_BUS_EN, MISC_IO_SLOW_SLEW,
    MEM_IO_SLOW_SLEW}) |-> $past(S_AXI_BVALID) && !$past(S_AXI_BVALID, 2))
    else $error("config output moved without write");
  a_pin_en_time: assert property ($changed(ENV_STRAP_OE_N) |->
    $past(S_AXI_BVALID) && !$past(S_AXI_BVALID, 2)) else $error("pin enable moved");
  a_pin_drive: assert property ($past(stepped) |->
    ((~ENV_STRAP_OE_N) & (ENV_STRAP_O ^
    {$past(SLOW_CLOCK_IN), $past(MAIN_CLOCK_IN), $past(PLL_CLOCK_IN)})) == 3'h0)
    else $error("pin drives wrong clock");
  a_wr_blocked: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
    else $error("write accepted while answering");
  c_stat_read: cover property (ar_hs && ar_st);
  c_pins_all_on: cover property (ENV_STRAP_OE_N == 3'h0);
  c_usb_low: cover property ($rose(USB_XCVR_LOW_POWER));
endmodule // scsr_top_monitor

bind scsr_top scsr_top_monitor u_mon (.CLK, .RESET_N, .CE, .S_AXI_AWREADY, .S_AXI_WREADY,
  .S_AXI_BVALID, .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP,
  .S_AXI_RVALID, .ENV_STRAP_I, .ENV_STRAP_O, .ENV_STRAP_OE_N, .PLL_CLOCK_IN, .MAIN_CLOCK_IN,
  .SLOW_CLOCK_IN, .USB_CTRL_LOW_POWER_REQ, .FUNC_WORD_USB_ENABLE, .FLASH_INTERFACE_BUSY,
  .DATA_FLASH_BUSY, .IO_ZONE_EXTERNAL_BUS_EN, .USB_XCVR_LOW_POWER, .MISC_IO_SLOW_SLEW,
  .MEM_IO_SLOW_SLEW);

// ===== tb/scsr_top_tb_top.sv
// Self-checking bench for the system configuration and status bank.
`timescale 1ns/1ps
`include "scsr_regs.vh"
module scsr_top_tb_top;
  logic        clk, reset_n, awvalid, wvalid, bready, arvalid, rready;
  logic [23:0] awaddr, araddr;
  logic [31:0] wdata, tmp;
  logic [3:0]  wstrb;
  logic [2:0]  strap_ext, clk_src, s;
  logic        usb_req, fw_en, pf_busy, df_busy, ce;
  logic [7:0]  d, cfg_exp;
  wire         awready, wready, arready, bvalid, rvalid, io_en, usb_lp, misc_slew, mem_slew;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire  [2:0]  pin_o, pin_oe_n, pin_lvl;
  int          n_errors = 0;
  int          n_compared = 0;

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, free-running clock sources and the strap wires, where a driving pin wins.
  always #20 clk = ~clk;
  always @(posedge clk) clk_src <= 3'($urandom);
  assign pin_lvl = (pin_oe_n & strap_ext) | (~pin_oe_n & pin_o);

  scsr_top u_dut (.CLK(clk), .RESET_N(reset_n), .CE(ce), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWPROT(3'h0), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARPROT(3'h0), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .ENV_STRAP_I(pin_lvl),
    .ENV_STRAP_O(pin_o), .ENV_STRAP_OE_N(pin_oe_n), .PLL_CLOCK_IN(clk_src[0]),
    .MAIN_CLOCK_IN(clk_src[1]), .SLOW_CLOCK_IN(clk_src[2]), .USB_CTRL_LOW_POWER_REQ(usb_req),
    .FUNC_WORD_USB_ENABLE(fw_en), .FLASH_INTERFACE_BUSY(pf_busy), .DATA_FLASH_BUSY(df_busy),
    .IO_ZONE_EXTERNAL_BUS_EN(io_en), .USB_XCVR_LOW_POWER(usb_lp),
    .MISC_IO_SLOW_SLEW(misc_slew), .MEM_IO_SLOW_SLEW(mem_slew));

  ////////////////////////////////////////////////////////////////////////////////
  // Comparison, verdict and expected output vector {usb, mem, misc, io, enables}.
  task automatic check(input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  task automatic summarize;
    $display("mismatches %0d, comparisons %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  function automatic logic [6:0] outs(input logic [7:0] c, input logic rq, input logic fe);
    return {!c[4] || rq || !fe, c[6], c[5], c[0], ~c[3:1]};
  endfunction
  task automatic chk_outs;
    check({25'h0, outs(cfg_exp, usb_req, fw_en)},
          {25'h0, usb_lp, mem_slew, misc_slew, io_en, pin_oe_n});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Bus cycles; each channel is held until its own ready, the answer is then checked.
  task automatic wr(input logic [23:0] a, input logic [7:0] v, input logic [3:0] st,
                    input logic [1:0] er);
    int n;
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h0, v};
    wstrb <= st;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 50);
    bready <= 1'b0;
    if (n >= 50) n_errors++;
    check({30'h0, er}, {30'h0, bresp});
  endtask
  task automatic rdc(input logic [23:0] a, input logic [31:0] e, input logic [1:0] er);
    int n;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 50);
    rready <= 1'b0;
    if (n >= 50) n_errors++;
    check(e, rdata);
    check({30'h0, er}, {30'h0, rresp});
  endtask
  task automatic rst(input logic [2:0] sv);
    @(posedge clk);
    reset_n <= 1'b0;
    strap_ext <= sv;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    strap_ext <= ~sv;
    cfg_exp = 8'h10;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence; the bench starts no flash work itself.
  initial begin
    {clk, reset_n, awvalid, wvalid, bready, arvalid, rready} = 7'h0;
    {awaddr, araddr, wdata, wstrb, clk_src} = 87'h0;
    {usb_req, fw_en, pf_busy, df_busy} = 4'h4;
    ce = 1'b1;
    tmp = $urandom(22);
    s = 3'($urandom);
    rst(s);
    rdc(`SCSR_CFG_ADDR, 32'h10, 2'h0);
    chk_outs;
    rdc(`SCSR_STAT_ADDR, {29'h0, s}, 2'h0);
    for (int i = 0; i < 24; i++) begin
      d = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom);
      usb_req <= 1'($urandom);
      fw_en <= 1'($urandom);
      wr(`SCSR_CFG_ADDR, d, 4'h1, 2'h0);
      cfg_exp = d & 8'h7F;
      @(posedge clk);
      chk_outs;
      rdc(`SCSR_CFG_ADDR, {24'h0, cfg_exp}, 2'h0);
    end
    wr(`SCSR_CFG_ADDR, ~cfg_exp, 4'h0, 2'h0);
    wr(`SCSR_STAT_ADDR, 8'hFF, 4'h1, 2'h0);
    wr(24'hFFF918, 8'h01, 4'h1, 2'h2);
    rdc(24'hFFF911, 32'h0, 2'h2);
    rdc(`SCSR_CFG_ADDR, {24'h0, cfg_exp}, 2'h0);
    for (int b = 0; b < 4; b++) begin
      @(posedge clk);
      {df_busy, pf_busy} <= 2'(b);
      rdc(`SCSR_STAT_ADDR, {27'h0, 2'(b), s}, 2'h0);
    end
    // Clock enable low for five edges: the busy copy must keep its old value
    // and the read must wait, so the answer still shows both flags set.
    ce <= 1'b0;
    {df_busy, pf_busy} <= 2'h0;
    fork
      rdc(`SCSR_STAT_ADDR, {27'h0, 2'h3, s}, 2'h0);
      begin
        repeat (5) @(posedge clk);
        ce <= 1'b1;
      end
    join
    {df_busy, pf_busy} <= 2'h3;
    repeat (20) @(posedge clk);
    chk_outs;
    s = ~s;
    rst(s);
    rdc(`SCSR_CFG_ADDR, 32'h10, 2'h0);
    rdc(`SCSR_STAT_ADDR, {27'h0, 2'h3, s}, 2'h0);
    chk_outs;
    summarize;
  end

  // Watchdog sized well above the few hundred cycles the sequence needs.
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    summarize;
  end
endmodule // scsr_top_tb_top
